// ===== logic/dcrd_consts.svh
// register offsets, field positions, reset values for the rank decoder
`ifndef DCRD_CONSTS_SVH
`define DCRD_CONSTS_SVH
`define DCRD_ADR_CTRL    8'h00
`define DCRD_ADR_CLKSEL  8'h04
`define DCRD_ADR_TIM     8'h08
`define DCRD_ADR_REF     8'h10
`define DCRD_ADR_BND     8'h20
`define DCRD_ADR_PAGE    8'h40
`define DCRD_ADR_STAT    8'h48
`define DCRD_CH_STRIDE   8'h10
`define DCRD_CTRL_ILV    0
`define DCRD_CTRL_SMALL  1
`define DCRD_LINE_BIT    6
`define DCRD_UNIT_LSB    25
`define DCRD_RST_CTRL    32'h0000_0000
`define DCRD_RST_CLKSEL  3'h0
`define DCRD_RST_TIM     32'h0000_0000
`define DCRD_RST_REF     32'h0000_0000
`define DCRD_RST_BND     8'h00
`define DCRD_RST_PAGE    16'h0000
`endif

// ===== logic/dcrd_pkg.sv
// types shared by the rank decoder modules
package dcrd_pkg;
    // page size code held per rank (3 bits)
    typedef enum logic [2:0] {
        DCRD_PG_4K_B4 = 3'h0,
        DCRD_PG_8K_B4 = 3'h1,
        DCRD_PG_8K_B8 = 3'h2
    } dcrd_page_t;

    // host request into the decoder
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } dcrd_req_t;

    // decoded memory target
    typedef struct packed {
        logic        valid;
        logic        miss;
        logic        chan;
        logic [1:0]  rank;
        logic [3:0]  cs;
        logic        pair;
        logic [15:0] row;
        logic [2:0]  bank;
        logic [9:0]  col;
    } dcrd_dec_t;
endpackage : dcrd_pkg

// ===== logic/dcrd_rank_find.sv
// finds the rank whose boundary covers an address, per channel
`timescale 1ns/1ps
module dcrd_rank_find
    import dcrd_pkg::*;
(
    input  wire logic [7:0]  unit_i,  // address in 32 MB units
    input  wire logic [7:0]  floor_i, // bottom of this channel
    input  wire logic [31:0] bnd_i,   // four cumulative tops, rank 0 low
    output logic             hit_o,   // some rank covers the address
    output logic [1:0]       rank_o,  // covering rank
    output logic [7:0]       base_o   // bottom of that rank
);
    logic [31:0] prv; // bottom of each rank

    // empty ranks repeat the previous top and are skipped by the compare
    always_comb
    begin
        prv    = {bnd_i[23:0], floor_i};
        hit_o  = 1'b0;
        rank_o = 2'h0;
        base_o = floor_i;
        for (int r = 3; r >= 0; r--)
        begin
            // lowest covering rank wins since it is visited last
            if (unit_i < bnd_i[8*r +: 8])
            begin
                hit_o  = 1'b1;
                rank_o = 2'(r);
                base_o = prv[8*r +: 8];
            end
        end
    end
endmodule : dcrd_rank_find

// ===== logic/dcrd_top.sv
// two-channel rank decoder with its configuration registers
`timescale 1ns/1ps
`include "dcrd_consts.svh"
// Behaviour
// - interleaved: channel flips every 64-byte line
// - interleaved: next line sits on other channel
// - asymmetric: low addresses fill channel A
// - asymmetric: then channel B bottom to top
// - asymmetric: any rank population, one channel ok
// - one top boundary per rank, four per channel
// - interleaved boundaries describe rank pairs
// - 3-bit page setting, two per byte
// - interleaved page setting covers rank pair
// - one memory clock select for all DIMMs
// - timing setting per channel, A=0 B=1
// - per-channel refresh control setting
// - 256Mb, 512Mb, 1Gb, x8 and x16 addressing
// - ranks counted by chip select
// - memory limited to 4 GB or 2 GB
// - channel bit replaces host address bit 6
module dcrd_top
    import dcrd_pkg::*;
(
    input  wire logic             clk_i,      // 10 MHz clock
    input  wire logic             rst_i,      // sync reset, high
    input  wire logic             wb_cyc_i,   // bus cycle
    input  wire logic             wb_stb_i,   // bus strobe
    input  wire logic             wb_we_i,    // write
    input  wire logic [7:0]       wb_adr_i,   // byte address
    input  wire logic [3:0]       wb_sel_i,   // byte enables
    input  wire logic [31:0]      wb_dat_i,   // write data
    output logic [31:0]           wb_dat_o,   // read data
    output logic                  wb_ack_o,   // acknowledge
    input  wire dcrd_req_t        req_i,      // host request
    output dcrd_dec_t             dec_o,      // decoded target
    output logic [2:0]            mem_clk_sel_o, // clock select to DIMMs
    output logic [1:0][31:0]      chan_timing_o, // timing per channel
    output logic [1:0][31:0]      chan_refresh_o // refresh per channel
);
    // ******************************************************
    // bus slave
    // ******************************************************
    logic        ack_q;    // answer flag
    logic [31:0] rdata_q;  // captured read word
    logic [31:0] rd_d;     // read mux
    logic        start;    // request seen, not yet answered
    logic        wr_go;    // write takes effect this edge
    logic [31:0] ctrl_q;   // mode control
    logic [2:0]  clksel_q; // memory clock select
    logic [7:0]  bnd_q [2][4]; // rank tops in 32 MB units
    logic [15:0] page_q [2];   // four 3-bit page codes per channel
    dcrd_dec_t   dec_q;    // registered result
    dcrd_dec_t   dec_d;    // next result

    assign start = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // byte-enable merge of a write into a register
    function automatic logic [31:0] dcrd_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : dcrd_merge

    // one-cycle answer; ack drops the cycle after it was given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= start;
        end
    end

    // read word is captured as the request is taken
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (start)
        begin
            rdata_q <= rd_d;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (wb_adr_i)
            `DCRD_ADR_CTRL:        rd_d = ctrl_q;
            `DCRD_ADR_CLKSEL:      rd_d = {29'h0, clksel_q};
            `DCRD_ADR_TIM:         rd_d = chan_timing_o[0];
            `DCRD_ADR_TIM + 8'h4:  rd_d = chan_timing_o[1];
            `DCRD_ADR_REF:         rd_d = chan_refresh_o[0];
            `DCRD_ADR_REF + 8'h4:  rd_d = chan_refresh_o[1];
            `DCRD_ADR_PAGE:        rd_d = {16'h0, page_q[0]};
            `DCRD_ADR_PAGE + 8'h4: rd_d = {16'h0, page_q[1]};
            // status shows the last decode
            `DCRD_ADR_STAT:        rd_d = {26'h0, dec_q.valid, dec_q.miss,
                                           dec_q.pair, dec_q.chan, dec_q.rank};
            default:   rd_d = (wb_adr_i[7:5] == 3'h1 && wb_adr_i[1:0] == 2'h0) ?
                              {24'h0, bnd_q[wb_adr_i[4]][wb_adr_i[3:2]]} : 32'h0;
        endcase
    end

    // ******************************************************
    // configuration registers
    // ******************************************************
    // mode control: interleave and reduced-size variant
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `DCRD_RST_CTRL;
        end
        else if (wr_go && wb_adr_i == `DCRD_ADR_CTRL)
        begin
            ctrl_q <= dcrd_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
        end
    end

    // one clock select drives every DIMM
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clksel_q <= `DCRD_RST_CLKSEL;
        end
        else if (wr_go && wb_adr_i == `DCRD_ADR_CLKSEL && wb_sel_i[0])
        begin
            clksel_q <= wb_dat_i[2:0];
        end
    end
    assign mem_clk_sel_o = clksel_q;

    // per-channel timing, refresh, boundaries and page codes
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        // channel index 0 is A, 1 is B
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                chan_timing_o[c]  <= `DCRD_RST_TIM;
                chan_refresh_o[c] <= `DCRD_RST_REF;
            end
            else if (wr_go && wb_adr_i == 8'(`DCRD_ADR_TIM + 4*c))
            begin
                chan_timing_o[c] <= dcrd_merge(chan_timing_o[c], wb_dat_i,
                                               wb_sel_i);
            end
            else if (wr_go && wb_adr_i == 8'(`DCRD_ADR_REF + 4*c))
            begin
                chan_refresh_o[c] <= dcrd_merge(chan_refresh_o[c], wb_dat_i,
                                                wb_sel_i);
            end
        end
        // two page codes per byte, bits 2:0 and 6:4; bits 3 and 7 stay zero
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                page_q[c] <= `DCRD_RST_PAGE;
            end
            else if (wr_go && wb_adr_i == 8'(`DCRD_ADR_PAGE + 4*c))
            begin
                page_q[c] <= 16'(dcrd_merge({16'h0, page_q[c]}, wb_dat_i,
                                            wb_sel_i) & 32'h0000_7777);
            end
        end
        for (genvar r = 0; r < 4; r++)
        begin : g_rk
            // rank top boundary, one per rank
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    bnd_q[c][r] <= `DCRD_RST_BND;
                end
                else if (wr_go && wb_sel_i[0] &&
                         wb_adr_i == 8'(`DCRD_ADR_BND + 16*c + 4*r))
                begin
                    bnd_q[c][r] <= wb_dat_i[7:0];
                end
            end
        end
    end
    // ******************************************************
    // address decode
    // ******************************************************
    logic       ilv;            // interleaved mode
    logic [7:0] unit;           // address in 32 MB units
    logic       hit_a, hit_b;   // rank found per channel
    logic [1:0] rk_a, rk_b;     // rank per channel
    logic [7:0] base_a, base_b; // rank bottom per channel
    logic [31:0] off_sys;       // offset inside rank, system space
    logic [31:0] off;           // offset inside rank, channel space
    logic [2:0]  pg;            // page code of chosen rank
    logic [7:0]  base;          // chosen rank bottom
    logic        hit;           // chosen rank covers address
    assign ilv  = ctrl_q[`DCRD_CTRL_ILV];
    assign unit = {1'b0, req_i.addr[31:`DCRD_UNIT_LSB]};
    // channel A starts at zero; B starts at A's top
    dcrd_rank_find u_find_a (
        .unit_i  (unit),
        .floor_i (8'h00),
        .bnd_i   ({bnd_q[0][3], bnd_q[0][2], bnd_q[0][1], bnd_q[0][0]}),
        .hit_o   (hit_a),
        .rank_o  (rk_a),
        .base_o  (base_a)
    );
    dcrd_rank_find u_find_b (
        .unit_i  (unit),
        .floor_i (bnd_q[0][3]),
        .bnd_i   ({bnd_q[1][3], bnd_q[1][2], bnd_q[1][1], bnd_q[1][0]}),
        .hit_o   (hit_b),
        .rank_o  (rk_b),
        .base_o  (base_b)
    );
    // choose channel and rank, then split the offset into row/bank/col
    always_comb
    begin
        dec_d       = '0;
        dec_d.valid = req_i.valid;
        if (ilv)
        begin
            // boundaries describe rank pairs; bit 6 picks the channel
            dec_d.chan = req_i.addr[`DCRD_LINE_BIT];
            dec_d.rank = rk_a;
            hit        = hit_a;
            base       = base_a;
        end
        else if (hit_a)
        begin
            dec_d.chan = 1'b0;
            dec_d.rank = rk_a;
            hit        = 1'b1;
            base       = base_a;
        end
        else
        begin
            // empty channels simply never hit
            dec_d.chan = 1'b1;
            dec_d.rank = rk_b;
            hit        = hit_b;
            base       = base_b;
        end
        // reduced variant cannot reach the upper 2 GB
        dec_d.miss = ~hit | (ctrl_q[`DCRD_CTRL_SMALL] & req_i.addr[31]);
        dec_d.pair = ilv & ~dec_d.miss;
        dec_d.cs   = dec_d.miss ? 4'h0 : 4'h1 << dec_d.rank;
        off_sys    = req_i.addr - 32'({base, 25'h0});
        // squeeze out the channel bit inside the rank pair
        off = ilv ? {1'b0, off_sys[31:7], off_sys[5:0]} : off_sys;
        pg  = ilv ? page_q[0][4*dec_d.rank +: 3]
                  : page_q[dec_d.chan][4*dec_d.rank +: 3];
        // unknown codes fall back to the 8 KB four-bank split
        unique case (pg)
            DCRD_PG_4K_B4:
            begin
                dec_d.col  = {1'b0, off[11:3]};
                dec_d.bank = {1'b0, off[13:12]};
                dec_d.row  = 16'(off[31:14]);
            end
            DCRD_PG_8K_B8:
            begin
                dec_d.col  = off[12:3];
                dec_d.bank = off[15:13];
                dec_d.row  = 16'(off[31:16]);
            end
            default:
            begin
                dec_d.col  = off[12:3];
                dec_d.bank = {1'b0, off[14:13]};
                dec_d.row  = 16'(off[31:15]);
            end
        endcase
    end
    // result is registered one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dec_q <= '0;
        end
        else
        begin
            dec_q <= dec_d;
        end
    end
    assign dec_o = dec_q;
    // ******************************************************
    // checks
    // ******************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence clk_wr_s;
        wr_go && wb_adr_i == `DCRD_ADR_CLKSEL && wb_sel_i[0];
    endsequence
    ilv_chan_a: assert property (req_i.valid && ilv
        |=> dec_o.chan == $past(req_i.addr[6])) else $error("line channel wrong");
    pair_opp_a: assert property (dec_o.valid && dec_o.pair
        |-> dec_o.chan == $past(req_i.addr[6])) else $error("pair not split");
    asym_low_a: assert property (req_i.valid && !ilv && unit < bnd_q[0][3]
        |=> dec_o.chan == 1'b0) else $error("low addr left A");
    asym_high_a: assert property (req_i.valid && !ilv && unit >= bnd_q[0][3]
        |=> dec_o.chan == 1'b1) else $error("high addr not on B");
    cs_one_a: assert property (dec_o.valid && !dec_o.miss
        |-> dec_o.cs == 4'h1 << dec_o.rank) else $error("chip select wrong");
    size_cap_a: assert property (req_i.valid && ctrl_q[1] && req_i.addr[31]
        |=> dec_o.miss && dec_o.cs == 4'h0) else $error("above 2 GB routed");
    top_miss_a: assert property (req_i.valid && unit >= bnd_q[1][3]
        && unit >= bnd_q[0][3] |=> dec_o.miss) else $error("above top routed");
    clk_take_a: assert property (clk_wr_s
        |=> mem_clk_sel_o == $past(wb_dat_i[2:0])) else $error("clock select lost");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
endmodule : dcrd_top

// ===== bench/dcrd_dimm_model.sv
// rank population model fed by the decoder chip selects
`timescale 1ns/1ps
module dcrd_dimm_model
    import dcrd_pkg::*;
(
    input  wire dcrd_dec_t dec_i, // decoded target
    output logic           hit_o, // exactly one rank selected
    output logic [2:0]     id_o   // channel and rank answering
);
    // ****************************************
    // rank answer
    // ****************************************
    // one select per rank, so a two-sided module on one select is one rank
    always_comb
    begin
        hit_o = dec_i.valid && $onehot(dec_i.cs);
        id_o  = {dec_i.chan, 2'h0};
        for (int i = 1; i < 4; i++)
        begin
            if (dec_i.cs[i])
                id_o = {dec_i.chan, 2'(i)};
        end
    end
endmodule : dcrd_dimm_model

// ===== bench/dcrd_top_bench.sv
// self-checking bench for the two-channel rank decoder
`timescale 1ns/1ps
`include "dcrd_consts.svh"
module dcrd_top_bench
    import dcrd_pkg::*;
;
    // ****************************************
    // signals and instances
    // ****************************************
    logic             clk_i = 1'h0;  // 100 ns clock
    logic             rst_i = 1'h1;  // sync reset
    logic             cyc   = 1'h0;  // bus cycle
    logic             stb   = 1'h0;  // bus strobe
    logic             we    = 1'h0;  // write
    logic [7:0]       adr   = 8'h00; // byte address
    logic [3:0]       sel   = 4'h0;  // byte enables
    logic [31:0]      wdat  = 32'h0; // write data
    logic [31:0]      rdat;          // read data
    logic             ack;           // acknowledge
    dcrd_req_t        req   = '0;    // host request
    dcrd_dec_t        dec;           // decoded target
    logic [2:0]       ck_sel;        // memory clock select
    logic [1:0][31:0] tim;           // timing per channel
    logic [1:0][31:0] refr;          // refresh per channel
    logic             hit;           // model saw one rank
    logic [2:0]       id;            // model channel and rank
    int               failures = 0;  // mismatches
    int               cmp_count = 0; // comparisons

    // free-running clock
    always #50 clk_i = ~clk_i;

    dcrd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .req_i(req), .dec_o(dec), .mem_clk_sel_o(ck_sel),
        .chan_timing_o(tim), .chan_refresh_o(refr));

    dcrd_dimm_model ranks (.dec_i(dec), .hit_o(hit), .id_o(id));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // one classic cycle; waits for ack, only the watchdog ends a dead wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'h1)
        begin
            n++;
            @(posedge clk_i);
        end
        check(32'(n), 32'h1, "ack latency");
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        check(q, e, s);
    endtask : rd

    // four rank tops of one channel, rank 0 in the low byte
    task automatic bnd(input int c, input logic [31:0] v);
        for (int r = 0; r < 4; r++)
            wr(8'(`DCRD_ADR_BND + c * `DCRD_CH_STRIDE + 4 * r), {24'h0, v[8 * r +: 8]});
    endtask : bnd

    // t is {channel, rank}; decode shows just after the edge that samples the request;
    // the request drops again there so register writes see no live decode
    task automatic dc(input logic [31:0] a, input logic m, input logic [2:0] t,
                      input logic p);
        @(posedge clk_i);
        req <= '{valid: 1'h1, addr: a};
        @(posedge clk_i);
        req <= '0;
        #1;
        check(dec.valid, 1'h1, "valid");
        check(dec.miss, m, "miss");
        check(dec.pair, p, "pair");
        check(dec.cs, m ? 4'h0 : 4'h1 << t[1:0], "cs");
        check(hit, !m, "rank hit");
        if (!m)
        begin
            check({dec.chan, dec.rank}, t, "target");
            check(id, t, "model rank");
        end
    endtask : dc

    // row, bank and column split of a rank offset for a page code
    task automatic fld(input logic [31:0] off, input logic [2:0] code);
        logic [9:0]  col;
        logic [2:0]  bk;
        logic [15:0] row;
        col = off[12:3];
        bk = {1'h0, off[14:13]};
        row = 16'(off >> 15);
        if (code == 3'h0)
        begin
            col = {1'h0, off[11:3]};
            bk = {1'h0, off[13:12]};
            row = 16'(off >> 14);
        end
        else if (code == 3'h2)
        begin
            bk = off[15:13];
            row = 16'(off >> 16);
        end
        check({dec.row, dec.bank, dec.col}, {row, bk, col}, "fields");
    endtask : fld

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(`DCRD_ADR_CTRL, `DCRD_RST_CTRL, "ctrl rst");
        rd(`DCRD_ADR_BND + 8'h1c, 32'(`DCRD_RST_BND), "bnd rst");
        rd(`DCRD_ADR_PAGE, 32'(`DCRD_RST_PAGE), "page rst");
        check(ck_sel, `DCRD_RST_CLKSEL, "clk sel rst");
        check(tim[1], `DCRD_RST_TIM, "tim rst");
        check(refr[0], `DCRD_RST_REF, "ref rst");
        dc(32'h0, 1'h1, 3'h0, 1'h0);
    endtask : t_reset

    task automatic t_regs();
        wr(`DCRD_ADR_CLKSEL, 32'h5);
        wr(`DCRD_ADR_TIM, 32'h1234_5678);
        wr(`DCRD_ADR_TIM + 8'h4, 32'h9abc_def0);
        wr(`DCRD_ADR_REF, 32'h0000_00a5);
        wr(`DCRD_ADR_REF + 8'h4, 32'h5a00_0000);
        rd(`DCRD_ADR_CLKSEL, 32'h5, "clk sel");
        check(ck_sel, 3'h5, "clk out");
        check(tim[0], 32'h1234_5678, "tim a");
        check(tim[1], 32'h9abc_def0, "tim b");
        check(refr[0], 32'h0000_00a5, "ref a");
        check(refr[1], 32'h5a00_0000, "ref b");
        wr(`DCRD_ADR_PAGE, 32'hffff_ffff);
        rd(`DCRD_ADR_PAGE, 32'h0000_7777, "page pack");
        wr(`DCRD_ADR_BND, 32'h0000_01ab);
        rd(`DCRD_ADR_BND, 32'h0000_00ab, "bnd byte");
        wr(8'h60, 32'hffff_ffff);
        rd(8'h60, 32'h0, "unmapped");
    endtask : t_regs

    task automatic t_asym();
        wr(`DCRD_ADR_CTRL, 32'h0);
        bnd(0, 32'h2828_2010);
        bnd(1, 32'h5050_4838);
        wr(`DCRD_ADR_PAGE, 32'h0000_0210);
        dc(32'h0000_0000, 1'h0, 3'h0, 1'h0);
        dc(32'h1fff_ffc0, 1'h0, 3'h0, 1'h0);
        dc(32'h0001_2348, 1'h0, 3'h0, 1'h0);
        fld(32'h0001_2348, 3'h0);
        dc(32'h2001_2348, 1'h0, 3'h1, 1'h0);
        fld(32'h0001_2348, 3'h1);
        dc(32'h4001_2348, 1'h0, 3'h2, 1'h0);
        fld(32'h0001_2348, 3'h2);
        dc(32'h4fff_ffff, 1'h0, 3'h2, 1'h0);
        dc(32'h5000_0000, 1'h0, 3'h4, 1'h0);
        dc(32'h8000_0000, 1'h0, 3'h5, 1'h0);
        dc(32'h9fff_fff0, 1'h0, 3'h6, 1'h0);
        dc(32'ha000_0000, 1'h1, 3'h0, 1'h0);
        wr(`DCRD_ADR_CTRL, 32'h2);
        dc(32'h7fff_ffc0, 1'h0, 3'h5, 1'h0);
        dc(32'h8000_0000, 1'h1, 3'h0, 1'h0);
    endtask : t_asym

    // only channel B populated, ranks 1 to 3 empty
    task automatic t_onech();
        wr(`DCRD_ADR_CTRL, 32'h0);
        bnd(0, 32'h0);
        bnd(1, 32'h1010_1010);
        dc(32'h0000_0040, 1'h0, 3'h4, 1'h0);
        dc(32'h2000_0000, 1'h1, 3'h0, 1'h0);
    endtask : t_onech

    task automatic t_ilv();
        bnd(0, 32'h5050_4020);
        bnd(1, 32'h5050_4020);
        wr(`DCRD_ADR_PAGE, 32'h0);
        wr(`DCRD_ADR_PAGE + 8'h4, 32'h2222);
        wr(`DCRD_ADR_CTRL, 32'h1);
        // lines straddle the rank 0 to rank 1 boundary
        for (int i = 0; i < 4; i++)
            dc(32'h3fff_ff80 + 32'(i * 64), 1'h0, {i[0], 1'h0, i[1]}, 1'h1);
        dc(32'h0000_21c8, 1'h0, 3'h4, 1'h1);
        fld(32'h0000_10c8, 3'h0);
        dc(32'ha000_0000, 1'h1, 3'h0, 1'h0);
        // idle request at address 0 now decodes as a hit pair on A rank 0
        rd(`DCRD_ADR_STAT, 32'h0000_0008, "status");
    endtask : t_ilv

    // ****************************************
    // run control
    // ****************************************
    task automatic stop_test();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_regs();
        t_asym();
        t_onech();
        t_ilv();
        stop_test();
    end

    // watchdog: the whole run needs well under 2000 cycles
    initial
    begin
        #(20000 * 100);
        failures++;
        stop_test();
    end
endmodule : dcrd_top_bench
